/* File: rtl/cgc_top.sv */
// Charge gauge counter core with its single-wire register port.
// Assumes converter counts arrive as strobes on clk_i; pins are async.
`timescale 1ns/1ps
`include "cgc_defs.svh"
module cgc_top #(
  parameter int unsigned SEC_CYC = 20_000_000,
  parameter int unsigned DISP_HOLD_CYC = 200_000_000,
  parameter int unsigned CYCB_MAX_CYC = 5000,
  parameter int unsigned TX_CYC_CYC = 4400
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire cgc_pkg::cgc_sense_s sense_i,
  input wire cgc_pkg::cgc_cfg_s cfg_i,
  input wire logic [3:0] temp_code_i,
  input wire logic empty_warn_i,
  input wire logic full_charge_i,
  input wire logic serial_line_i,
  output logic serial_line_o,
  output logic serial_line_oe_o,
  output logic [15:0] avail_capacity_count_o,
  output logic [15:0] discharge_count_o,
  output logic [15:0] learned_capacity_o,
  output logic valid_discharge_flag_o,
  output logic charge_valid_o,
  output logic fast_charge_o,
  output logic empty_warn_o,
  output logic display_on_o
);
  import cgc_pkg::*;

  logic init_r, full_f_r, line_f_r, fast_r, chg_act_r, vdq_r, edv_r;
  logic edv_cold_r, chg_since_full_r, oe_r, line_o_r, disp_r, phase_r;
  logic [2:0] full_q_r, line_q_r;
  logic [15:0] nac_r, dcr_r, lmd_r, sd_cnt_r;
  logic [7:0] ch_acc_r, id_r, sh_r, cmd_r;
  logic [1:0] upd_r, sec_inc_r;
  logic [31:0] sec_r, sd_acc_r, hold_r;
  logic signed [16:0] v_last_r;
  logic [15:0] tcnt_r;
  logic [3:0] bitn_r;
  cgc_ser_e st_r;

  // ==========================================
  // Pin synchronisers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      full_q_r <= 3'h0;
      line_q_r <= 3'h7;
      full_f_r <= 1'b0;
      line_f_r <= 1'b1;
    end else begin
      full_q_r <= {full_q_r[1:0], full_charge_i};
      line_q_r <= {line_q_r[1:0], serial_line_i};
      if (full_q_r[1] == full_q_r[2]) full_f_r <= full_q_r[2];
      if (line_q_r[1] == line_q_r[2]) line_f_r <= line_q_r[2];
    end
  end

  // ==========================================
  // Sense classification and compensation
  logic signed [16:0] raw, vc, ofs;
  logic outside, chg_cnt, dis_cnt, chg_inc, sd_dec, valid_on, lmd_upd;
  logic [6:0] eff;
  logic [20:0] eff_set;
  logic [8:0] ch_sum;
  logic [4:0] sd_sh;
  logic [3:0] band;
  logic [31:0] sd_thr, sd_sum;
  logic [22:0] sd_lhs, sd_rhs;
  logic [15:0] lmd_floor;
  always_comb begin
    raw = 17'(sense_i.uv);
    unique case (cfg_i.offset_comp_select)
      CGC_PROG_H: ofs = `CGC_OFS_H_UV;
      CGC_PROG_Z: ofs = `CGC_OFS_Z_UV;
      default: ofs = 17'sd0;
    endcase
    outside = (raw > `CGC_ACT_UV) || (raw < -`CGC_ACT_UV);
    vc = outside ? 17'(raw + ofs) : raw;
    chg_cnt = sense_i.strobe && (vc > `CGC_ACT_UV);
    dis_cnt = sense_i.strobe && (vc < -`CGC_ACT_UV);
    // Efficiency in hundredths, picked by program, rate and temperature
    unique case (cfg_i.charge_comp_select)
      CGC_PROG_H: eff_set = fast_r ? `CGC_EFF_FAST : `CGC_EFF_H_TRK;
      CGC_PROG_L: eff_set = fast_r ? `CGC_EFF_FAST : `CGC_EFF_L_TRK;
      default: eff_set = `CGC_EFF_Z;
    endcase
    if (temp_code_i < `CGC_TEMP_30C) eff = eff_set[20:14];
    else if (temp_code_i < `CGC_TEMP_50C) eff = eff_set[13:7];
    else eff = eff_set[6:0];
    ch_sum = {1'b0, ch_acc_r} + {2'b00, eff};
    chg_inc = chg_cnt && (ch_sum >= {1'b0, `CGC_EFF_FULL});
    // Self-discharge: one count each time the AVAIL_CAPACITY_COUNT-weighted sum passes
    // the day length scaled by the band divisor
    if (temp_code_i <= `CGC_TEMP_0C) band = 4'd0;
    else if (temp_code_i - `CGC_TEMP_0C > `CGC_SD_BAND_MAX)
      band = `CGC_SD_BAND_MAX;
    else band = temp_code_i - `CGC_TEMP_0C;
    unique case (cfg_i.selfdis_rate_select)
      CGC_PROG_H: sd_sh = `CGC_SD_SH_H;
      CGC_PROG_Z: sd_sh = `CGC_SD_SH_Z;
      default: sd_sh = `CGC_SD_SH_L;
    endcase
    sd_thr = `CGC_DAY_S << (sd_sh - {1'b0, band});
    sd_sum = sd_acc_r + {16'h0000, nac_r};
    sd_dec = (sec_r == SEC_CYC - 1) && (sd_sum >= sd_thr);
    valid_on = chg_inc && chg_act_r && (upd_r == `CGC_VALID_UPD)
      && !charge_valid_o;
    sd_lhs = 23'(sd_cnt_r) * `CGC_PCT_FULL;
    sd_rhs = 23'(lmd_r) * `CGC_SD_PCT;
    lmd_upd = valid_on && edv_r && !chg_since_full_r && (sd_lhs < sd_rhs)
      && !edv_cold_r && vdq_r;
    lmd_floor = lmd_r - (lmd_r >> 2);
  end

  // ==========================================
  // Capacity, discharge and learned capacity counters
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_r <= 1'b1;
      nac_r <= 16'h0000;
      lmd_r <= 16'h0000;
      dcr_r <= 16'h0000;
    end else begin
      init_r <= 1'b0;
      if (init_r) lmd_r <= cfg_i.programmed_full_capacity;
      else if (lmd_upd)
        lmd_r <= (dcr_r < lmd_floor) ? lmd_floor : dcr_r;
      if (init_r) nac_r <= 16'h0000;
      else if (full_f_r) nac_r <= lmd_r;
      else if (valid_on && edv_r) nac_r <= 16'h0000;
      else if (chg_inc) begin
        // Self-discharge tick under a capacity increment is dropped
        if (nac_r < lmd_r) nac_r <= nac_r + 16'h0001;
      end else if ((dis_cnt || sd_dec) && nac_r != 16'h0000)
        nac_r <= nac_r - 16'h0001;
      if (nac_r == lmd_r) dcr_r <= 16'h0000;
      else if ((dis_cnt || (sd_dec && !chg_inc && nac_r != 16'h0000))
        && dcr_r != `CGC_DCR_MAX)
        dcr_r <= dcr_r + 16'h0001;
    end
  end

  // ==========================================
  // Charge accumulator, rate, validity
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ch_acc_r <= 8'h00;
      sec_r <= 32'h0000_0000;
      sec_inc_r <= 2'h0;
      fast_r <= 1'b0;
      sd_acc_r <= 32'h0000_0000;
      upd_r <= 2'h0;
      chg_act_r <= 1'b0;
      charge_valid_o <= 1'b0;
    end else begin
      if (chg_cnt)
        ch_acc_r <= chg_inc ? 8'(ch_sum - {1'b0, `CGC_EFF_FULL})
                            : 8'(ch_sum);
      if (sec_r == SEC_CYC - 1) begin
        sec_r <= 32'h0000_0000;
        fast_r <= (sec_inc_r >= `CGC_FAST_CNT);
        sec_inc_r <= 2'h0;
        sd_acc_r <= sd_dec ? sd_sum - sd_thr : sd_sum;
      end else begin
        sec_r <= sec_r + 32'h0000_0001;
        if (chg_inc && sec_inc_r != 2'h3) sec_inc_r <= sec_inc_r + 2'h1;
      end
      // Activity ends on a count at or below threshold
      if (chg_cnt) chg_act_r <= 1'b1;
      else if (sense_i.strobe) chg_act_r <= 1'b0;
      if (sense_i.strobe && !chg_cnt) upd_r <= 2'h0;
      else if (chg_inc && upd_r != 2'h3) upd_r <= upd_r + 2'h1;
      if (valid_on) charge_valid_o <= 1'b1;
      else if (sense_i.strobe && !chg_cnt) charge_valid_o <= 1'b0;
    end
  end

  // ==========================================
  // Flags; a set in the same cycle as a clear wins
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vdq_r <= 1'b0;
      edv_r <= 1'b0;
      edv_cold_r <= 1'b0;
      chg_since_full_r <= 1'b0;
      sd_cnt_r <= 16'h0000;
    end else begin
      if (full_f_r || (dis_cnt && nac_r == lmd_r)) begin
        vdq_r <= 1'b1;
        sd_cnt_r <= 16'h0000;
      end else begin
        if (lmd_upd || valid_on || (sd_lhs >= sd_rhs && vdq_r)
          || (empty_warn_i && !edv_r && temp_code_i < `CGC_TEMP_0C))
          vdq_r <= 1'b0;
        if (sd_dec && !chg_inc && sd_cnt_r != 16'hFFFF)
          sd_cnt_r <= sd_cnt_r + 16'h0001;
      end
      if (empty_warn_i && !edv_r) begin
        edv_r <= 1'b1;
        edv_cold_r <= temp_code_i < `CGC_TEMP_0C;
      end else if (valid_on) edv_r <= 1'b0;
      if (valid_on) chg_since_full_r <= 1'b1;
      else if (nac_r == lmd_r) chg_since_full_r <= 1'b0;
    end
  end

  // ==========================================
  // Display hold
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      v_last_r <= 17'sd0;
      hold_r <= 32'h0000_0000;
      disp_r <= 1'b0;
    end else begin
      if (sense_i.strobe) v_last_r <= vc;
      if (v_last_r < -`CGC_DISP_DIS_UV) hold_r <= DISP_HOLD_CYC;
      else if (hold_r != 32'h0000_0000) hold_r <= hold_r - 32'h0000_0001;
      disp_r <= cfg_i.display_enable && ((charge_valid_o
        && v_last_r > `CGC_DISP_CHG_UV)
        || v_last_r < -`CGC_DISP_DIS_UV || hold_r != 32'h0000_0000);
    end
  end

  // ==========================================
  // Serial port
  logic [7:0] rd_data, rx_byte;
  logic rx_bit;
  always_comb begin
    rx_bit = tcnt_r < 16'(`CGC_SAMPLE_CYC);
    rx_byte = {rx_bit, sh_r[7:1]};
    unique case (cmd_r[6:0])
      `CGC_ADR_FLAGS: rd_data = {charge_valid_o, init_r, 2'b00, vdq_r,
        fast_r, edv_r, 1'b0};
      `CGC_ADR_NACH: rd_data = nac_r[15:8];
      `CGC_ADR_NACL: rd_data = nac_r[7:0];
      `CGC_ADR_ID: rd_data = id_r;
      `CGC_ADR_LMDH: rd_data = lmd_r[15:8];
      `CGC_ADR_LMDL: rd_data = lmd_r[7:0];
      `CGC_ADR_DCRH: rd_data = dcr_r[15:8];
      `CGC_ADR_DCRL: rd_data = dcr_r[7:0];
      default: rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= CGC_S_IDLE;
      tcnt_r <= 16'h0000;
      bitn_r <= 4'h0;
      sh_r <= 8'h00;
      cmd_r <= 8'h00;
      phase_r <= 1'b0;
      id_r <= `CGC_ID_RST;
      oe_r <= 1'b0;
      line_o_r <= 1'b0;
    end else begin
      line_o_r <= 1'b0;
      oe_r <= 1'b0;
      if (tcnt_r != 16'hFFFF) tcnt_r <= tcnt_r + 16'h0001;
      unique case (st_r)
        CGC_S_IDLE: begin
          if (!line_f_r) begin
            st_r <= CGC_S_LOW;
            tcnt_r <= 16'h0000;
          end else if (bitn_r != 4'h0 && tcnt_r >= 16'(CYCB_MAX_CYC)) begin
            bitn_r <= 4'h0;
            phase_r <= 1'b0;
          end
        end
        CGC_S_LOW: begin
          if (tcnt_r >= 16'(`CGC_BRK_CYC)) st_r <= CGC_S_BRK;
          else if (line_f_r) begin
            st_r <= CGC_S_IDLE;
            tcnt_r <= 16'h0000;
            sh_r <= rx_byte;
            bitn_r <= bitn_r + 4'h1;
            if (bitn_r == 4'h7) begin
              bitn_r <= 4'h0;
              if (!phase_r) begin
                cmd_r <= rx_byte;
                if (rx_byte[7]) phase_r <= 1'b1;
                else st_r <= CGC_S_TXW;
              end else begin
                phase_r <= 1'b0;
                if (cmd_r[6:0] == `CGC_ADR_ID) id_r <= rx_byte;
              end
            end
          end
        end
        CGC_S_BRK: if (line_f_r) begin
          st_r <= CGC_S_REC;
          tcnt_r <= 16'h0000;
        end
        CGC_S_REC: begin
          if (!line_f_r) st_r <= CGC_S_BRK;
          else if (tcnt_r >= 16'(`CGC_BRK_REC_CYC)) begin
            st_r <= CGC_S_IDLE;
            bitn_r <= 4'h0;
            phase_r <= 1'b0;
          end
        end
        CGC_S_TXW: if (tcnt_r >= 16'(`CGC_TX_RESP_CYC)) begin
          st_r <= CGC_S_TX;
          tcnt_r <= 16'h0000;
          sh_r <= rd_data;
        end
        CGC_S_TX: begin
          // Pull low only; the pull-up returns the line high
          oe_r <= (tcnt_r < 16'(`CGC_TX_START_CYC)) ||
            (!sh_r[0] && tcnt_r < 16'(`CGC_TX_STOP_CYC));
          if (tcnt_r >= 16'(TX_CYC_CYC - 1)) begin
            tcnt_r <= 16'h0000;
            sh_r <= {1'b0, sh_r[7:1]};
            bitn_r <= bitn_r + 4'h1;
            if (bitn_r == 4'h7) begin
              bitn_r <= 4'h0;
              st_r <= CGC_S_IDLE;
            end
          end
        end
        default: st_r <= CGC_S_IDLE;
      endcase
    end
  end

  // ==========================================
  // Outputs: register copies
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      empty_warn_o <= 1'b0;
    end else begin
      empty_warn_o <= edv_r;
    end
  end
  assign serial_line_o = line_o_r;
  assign serial_line_oe_o = oe_r;
  assign avail_capacity_count_o = nac_r;
  assign discharge_count_o = dcr_r;
  assign learned_capacity_o = lmd_r;
  assign valid_discharge_flag_o = vdq_r;
  assign fast_charge_o = fast_r;
  assign display_on_o = disp_r;

  // ==========================================
  // Assertions
  sequence s_full_held;
    full_f_r ##1 full_f_r;
  endsequence
  property p_full_load;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_full_held |-> nac_r == $past(lmd_r) && vdq_r;
  endproperty
  a_full_load: assert property (p_full_load)
    else $error("full input did not load capacity");
  property p_nac_cap;
    @(posedge clk_i) disable iff (!rst_n_i)
    chg_inc && nac_r == lmd_r && !full_f_r && !lmd_upd |=> nac_r == lmd_r;
  endproperty
  a_nac_cap: assert property (p_nac_cap)
    else $error("capacity counter passed learned capacity");
  property p_dcr_sat;
    @(posedge clk_i) disable iff (!rst_n_i)
    dcr_r == `CGC_DCR_MAX && nac_r != lmd_r |=> dcr_r == `CGC_DCR_MAX;
  endproperty
  a_dcr_sat: assert property (p_dcr_sat)
    else $error("discharge counter wrapped");
  property p_dcr_clr;
    @(posedge clk_i) disable iff (!rst_n_i)
    nac_r == lmd_r |=> dcr_r == 16'h0000;
  endproperty
  a_dcr_clr: assert property (p_dcr_clr)
    else $error("discharge counter not cleared at full");
  property p_edv_clear;
    @(posedge clk_i) disable iff (!rst_n_i)
    valid_on && edv_r && !full_f_r && !init_r |=> nac_r == 16'h0000 && !edv_r;
  endproperty
  a_edv_clear: assert property (p_edv_clear)
    else $error("capacity not cleared on charge after empty");
  property p_lmd_floor;
    @(posedge clk_i) disable iff (!rst_n_i)
    lmd_upd |=> lmd_r >= $past(lmd_r) - ($past(lmd_r) >> 2);
  endproperty
  a_lmd_floor: assert property (p_lmd_floor)
    else $error("learned capacity fell by more than a quarter");
  property p_dis_dec;
    @(posedge clk_i) disable iff (!rst_n_i)
    dis_cnt && nac_r != 16'h0000 && !full_f_r && !init_r
      |=> nac_r == $past(nac_r) - 16'h0001;
  endproperty
  a_dis_dec: assert property (p_dis_dec)
    else $error("discharge count did not decrement capacity");
  property p_oe_tx;
    @(posedge clk_i) disable iff (!rst_n_i)
    oe_r |-> !line_o_r && $past(st_r) == CGC_S_TX;
  endproperty
  a_oe_tx: assert property (p_oe_tx)
    else $error("line driven outside a transmit");
endmodule

/* File: rtl/cgc_defs.svh */
// Constants for the charge gauge counter: thresholds, timing, addresses.
// Assumes a 20 MHz core clock; included by the package and the core.
`ifndef CGC_DEFS_SVH
`define CGC_DEFS_SVH
`define CGC_CLK_MHZ 20
// ==========================================
// Sense thresholds, microvolts
`define CGC_ACT_UV 17'sd250
`define CGC_DISP_CHG_UV 17'sd500
`define CGC_DISP_DIS_UV 17'sd2000
`define CGC_OFS_H_UV 17'sd150
`define CGC_OFS_Z_UV 17'sd75
// ==========================================
// Counting
`define CGC_VALID_UPD 2'd2
`define CGC_FAST_CNT 2'd2
`define CGC_SD_PCT 23'd6
`define CGC_PCT_FULL 23'd100
`define CGC_DCR_MAX 16'hFFFF
`define CGC_EFF_FULL 8'd100
`define CGC_EFF_H_TRK {7'd80, 7'd75, 7'd70}
`define CGC_EFF_L_TRK {7'd85, 7'd80, 7'd75}
`define CGC_EFF_FAST {7'd95, 7'd90, 7'd85}
`define CGC_EFF_Z {7'd100, 7'd100, 7'd100}
`define CGC_DAY_S 32'd86400
`define CGC_SD_SH_H 5'd8
`define CGC_SD_SH_Z 5'd9
`define CGC_SD_SH_L 5'd11
`define CGC_SD_BAND_MAX 4'd7
// Temperature codes, 10 degree steps
`define CGC_TEMP_0C 4'h4
`define CGC_TEMP_30C 4'h7
`define CGC_TEMP_50C 4'h9
// ==========================================
// Serial line timing, microseconds
`define CGC_SAMPLE_US 100
`define CGC_BRK_US 190
`define CGC_BRK_REC_US 40
`define CGC_TX_RESP_US 100
`define CGC_TX_START_US 40
`define CGC_TX_STOP_US 160
`define CGC_SAMPLE_CYC (`CGC_SAMPLE_US * `CGC_CLK_MHZ)
`define CGC_BRK_CYC (`CGC_BRK_US * `CGC_CLK_MHZ)
`define CGC_BRK_REC_CYC (`CGC_BRK_REC_US * `CGC_CLK_MHZ)
`define CGC_TX_RESP_CYC (`CGC_TX_RESP_US * `CGC_CLK_MHZ)
`define CGC_TX_START_CYC (`CGC_TX_START_US * `CGC_CLK_MHZ)
`define CGC_TX_STOP_CYC (`CGC_TX_STOP_US * `CGC_CLK_MHZ)
// ==========================================
// Serial register addresses
`define CGC_ADR_FLAGS 7'h01
`define CGC_ADR_NACH 7'h03
`define CGC_ADR_ID 7'h04
`define CGC_ADR_NACL 7'h17
`define CGC_ADR_LMDH 7'h20
`define CGC_ADR_LMDL 7'h21
`define CGC_ADR_DCRH 7'h22
`define CGC_ADR_DCRL 7'h23
`define CGC_ID_RST 8'h00
`endif

/* File: rtl/cgc_pkg.sv */
// Types shared by the charge gauge counter and its bench.
// Assumes cgc_defs.svh sits beside it.
package cgc_pkg;
  `include "cgc_defs.svh"
  // Program pin level: high, floating, low
  typedef enum logic [1:0] {
    CGC_PROG_H = 2'b00,
    CGC_PROG_Z = 2'b01,
    CGC_PROG_L = 2'b10
  } cgc_prog_e;
  typedef struct packed {
    logic strobe;
    logic signed [15:0] uv;
  } cgc_sense_s;
  typedef struct packed {
    cgc_prog_e selfdis_rate_select;
    cgc_prog_e charge_comp_select;
    cgc_prog_e offset_comp_select;
    logic display_enable;
    logic [15:0] programmed_full_capacity;
  } cgc_cfg_s;
  typedef enum logic [2:0] {
    CGC_S_IDLE = 3'b000,
    CGC_S_LOW = 3'b001,
    CGC_S_BRK = 3'b010,
    CGC_S_REC = 3'b011,
    CGC_S_TXW = 3'b100,
    CGC_S_TX = 3'b101
  } cgc_ser_e;
endpackage

/* File: verif/cgc_host.sv */
// Host model for the single-wire register port of the gauge core.
// Assumes a pull-up on the wire and a 20 MHz clk_i.
`timescale 1ns/1ps
module cgc_host (
  input wire logic clk_i,
  input wire logic line_i,
  output logic drive_o
);
  logic [7:0] rx_byte;
  initial drive_o = 1'b0;
  // ====================================
  // Sending: high gap first, low pulse last
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Gap first so a reply may follow the last rise at once
  task automatic bit_out(input logic b);
    wt(b ? 3200 : 800);
    drive_o <= 1'b1;
    wt(b ? 800 : 3200);
    drive_o <= 1'b0;
  endtask
  task automatic send(input logic [7:0] d, input int n);
    for (int i = 0; i < n; i++)
      bit_out(d[i]);
  endtask
  task automatic brk();
    wt(800);
    drive_o <= 1'b1;
    wt(4000);
    drive_o <= 1'b0;
    wt(1000);
  endtask
  // ====================================
  // Receiving: short low is a one
  task automatic get(output logic ok);
    int w;
    ok = 1'b1;
    // Let our own last release reach the wire before timing anything
    wt(1);
    for (int i = 0; i < 8; i++) begin
      w = 0;
      while (line_i && w < 6000) begin
        wt(1);
        w++;
      end
      ok &= w < 6000;
      w = 0;
      while (!line_i && w < 5000) begin
        wt(1);
        w++;
      end
      ok &= w < 5000;
      rx_byte[i] = w < 2000;
    end
  endtask
endmodule

/* File: verif/charge_gauge_counter_tb.sv */
// Self-checking bench for the charge gauge counter core.
// Assumes cgc_pkg and cgc_host are compiled first.
`timescale 1ns/1ps
module charge_gauge_counter_tb;
  import cgc_pkg::*;
  typedef enum {K_CAP, K_DCR, K_LMD, K_VDQ, K_CV, K_DSP, K_SER, K_EDV,
    K_FST} cgc_kind_e;
  typedef struct {cgc_kind_e k; logic [15:0] v;} cgc_note_s;
  cgc_note_s q[$];
  cgc_note_s n;
  event snap;
  int bad_count = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'hF876715F;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  cgc_sense_s sense_i = '0;
  cgc_cfg_s cfg_i = '{CGC_PROG_L, CGC_PROG_Z, CGC_PROG_L, 1'b1, 16'h0010};
  logic [3:0] temp_code_i = 4'h4;
  logic empty_warn_i = 1'b0;
  logic full_charge_i = 1'b0;
  logic host_oe, line_oe, valid_discharge_flag, cv, dsp, ok, edv, fst;
  logic [15:0] cap, discharge_count, learned_capacity;
  // Pull-up wins unless someone pulls low
  wire sline = !(host_oe | line_oe);
  always #25 clk_i = ~clk_i;
  // Short counts keep the run brief
  cgc_top #(.SEC_CYC(200), .DISP_HOLD_CYC(2000)) DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sense_i(sense_i), .cfg_i(cfg_i),
    .temp_code_i(temp_code_i), .empty_warn_i(empty_warn_i),
    .full_charge_i(full_charge_i), .serial_line_i(sline),
    .serial_line_o(), .serial_line_oe_o(line_oe),
    .avail_capacity_count_o(cap), .discharge_count_o(discharge_count),
    .learned_capacity_o(learned_capacity), .valid_discharge_flag_o(valid_discharge_flag),
    .charge_valid_o(cv), .fast_charge_o(fst), .empty_warn_o(edv),
    .display_on_o(dsp));
  cgc_host HOST (.clk_i(clk_i), .line_i(sline), .drive_o(host_oe));
  // ====================================
  // Checking
  task automatic tally(input logic good, input string m);
    cmp_count++;
    if (!good) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic chk_cnt(input logic [15:0] g, e);
    tally(g === e, $sformatf("count %h exp %h", g, e));
  endtask
  task automatic chk_flag(input logic g, e);
    tally(g === e, $sformatf("flag %b exp %b", g, e));
  endtask
  task automatic chk_byte(input logic [7:0] g, e);
    tally(g === e, $sformatf("byte %h exp %h", g, e));
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always begin
    @(snap);
    while (q.size() > 0) begin
      n = q.pop_front();
      case (n.k)
        K_CAP: chk_cnt(cap, n.v);
        K_DCR: chk_cnt(discharge_count, n.v);
        K_LMD: chk_cnt(learned_capacity, n.v);
        K_VDQ: chk_flag(valid_discharge_flag, n.v[0]);
        K_CV: chk_flag(cv, n.v[0]);
        K_DSP: chk_flag(dsp, n.v[0]);
        K_EDV: chk_flag(edv, n.v[0]);
        K_FST: chk_flag(fst, n.v[0]);
        default: chk_byte(HOST.rx_byte, n.v[7:0]);
      endcase
    end
  end
  // ====================================
  // Stimulus
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic ex(input cgc_kind_e k, input logic [15:0] v);
    q.push_back('{k, v});
  endtask
  // Outputs are read mid-cycle, well clear of the edge
  task automatic look(input int c);
    repeat (c) @(posedge clk_i);
    @(negedge clk_i);
    ->snap;
    // Checker drains the queue before new notes are pushed
    #1;
  endtask
  task automatic pulse(input logic signed [15:0] uv);
    @(posedge clk_i);
    sense_i <= '{1'b1, uv};
    @(posedge clk_i);
    sense_i.strobe <= 1'b0;
  endtask
  // Random discharge stays above the count threshold and below the display level
  task automatic dis_rnd(input int c);
    for (int i = 0; i < c; i++) begin
      seed = xs(seed);
      pulse(-16'sd251 - $signed({6'h00, seed[9:0]}));
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    ex(K_CAP, 16'h0000);
    ex(K_LMD, 16'h0010);
    look(2);
    dis_rnd(3);
    ex(K_CAP, 16'h0000);
    ex(K_DCR, 16'h0003);
    look(1);
    @(posedge clk_i);
    full_charge_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    pulse(16'sd1000);
    ex(K_CAP, 16'h0010);
    ex(K_VDQ, 16'h0001);
    ex(K_DCR, 16'h0000);
    look(1);
    @(posedge clk_i);
    full_charge_i <= 1'b0;
    HOST.send(8'h17, 3);
    HOST.brk();
    HOST.send(8'h17, 8);
    HOST.get(ok);
    if (!ok) begin
      bad_count++;
      conclude();
    end
    ex(K_SER, 16'h0010);
    look(0);
    pulse(-16'sd3000);
    ex(K_CAP, 16'h000F);
    ex(K_DSP, 16'h0001);
    look(1);
    pulse(-16'sd500);
    ex(K_DCR, 16'h0001);
    look(1);
    ex(K_DSP, 16'h0001);
    look(1790);
    ex(K_DSP, 16'h0000);
    look(400);
    dis_rnd(2);
    @(posedge clk_i);
    empty_warn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    empty_warn_i <= 1'b0;
    ex(K_EDV, 16'h0001);
    look(0);
    repeat (3) pulse(16'sd1000);
    ex(K_CAP, 16'h0000);
    ex(K_LMD, 16'h000C);
    ex(K_CV, 16'h0001);
    ex(K_DSP, 16'h0001);
    ex(K_EDV, 16'h0000);
    look(2);
    pulse(16'sd1000);
    ex(K_CAP, 16'h0001);
    look(1);
    pulse(-16'sd500);
    ex(K_CAP, 16'h0000);
    ex(K_CV, 16'h0000);
    look(1);
    // Long enough to fill a whole rate window and reach the cap
    repeat (110) pulse(16'sd1000);
    ex(K_FST, 16'h0001);
    ex(K_CAP, 16'h000C);
    ex(K_DCR, 16'h0000);
    look(1);
    @(posedge clk_i);
    conclude();
  end
endmodule
